// File: design/assl_pkg.sv
// Shared constants for the alarm, status and service request block
package assl_pkg;
	// Register width
	localparam int          REG_W          = 16;
	// Alarm register bit positions
	localparam int          ALM_JSYNC_BIT  = 0;
	localparam int          ALM_UNAV_BIT   = 1;
	localparam int          ALM_SYNTH_BIT  = 2;
	localparam int          ALM_INDSIG_BIT = 3;
	localparam int          ALM_BITERR_BIT = 4;
	localparam int          ALM_CODERR_BIT = 5;
	localparam int          ALM_PSYNC_BIT  = 6;
	localparam int          ALM_JHIT_BIT   = 7;
	localparam int          ALM_POWER_BIT  = 8;
	localparam int          ALM_TXCLK_BIT  = 9;
	localparam int          ALM_RXCLK_BIT  = 10;
	localparam int          ALM_RXDAT_BIT  = 11;
	localparam int          ALM_LIMIT_BIT  = 12;
	// Primary status bit positions driven by this block
	localparam int          STA_REQ_BIT    = 6;
	localparam int          STA_CHG_BIT    = 9;
	// Reset values and fixed masks
	localparam logic [15:0] MASK_RST       = 16'h0000;
	localparam logic [15:0] ALARM_RST      = 16'h0000;
	localparam logic [15:0] ALL_ONES       = 16'hFFFF;
	localparam logic [15:0] ALARM_USED     = 16'h1FFF;
	// Mask command argument kinds
	typedef enum logic [1:0] {
		ASSL_MASK_VALUE = 2'b00,
		ASSL_MASK_NAME  = 2'b01,
		ASSL_MASK_ON    = 2'b10,
		ASSL_MASK_OFF   = 2'b11
	} assl_mask_op_t;
endpackage : assl_pkg

// File: design/assl_alarm_reg.sv
// Live alarm register built from synchronised alarm conditions
`timescale 1ns/1ns
module assl_alarm_reg (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [15:0] alarm_raw,
	input  wire logic        gating_start,
	input  wire logic        gating_active,
	input  wire logic        scan_at_max,
	input  wire logic        scan_at_min,
	output logic      [15:0] live_alarm_flags
);
	logic [15:0] sync1_reg;    // First stage, read only by stage two
	logic [15:0] sync2_reg;    // Safe copy of the raw conditions
	logic [1:0]  scan_s1_reg;  // Scan limit first stage
	logic [1:0]  scan_s2_reg;  // Scan limit second stage
	logic        unav_reg;     // Unavailability with history
	logic        power_reg;    // Power loss history
	logic        limit_reg;    // Scan extremity flag
	logic [15:0] live_next;    // Next register image

	// Two-flop synchroniser on every alarm input from the pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg   <= assl_pkg::ALARM_RST;
			sync2_reg   <= assl_pkg::ALARM_RST;
			scan_s1_reg <= 2'h0;
			scan_s2_reg <= 2'h0;
		end else begin
			sync1_reg   <= alarm_raw;
			sync2_reg   <= sync1_reg;
			scan_s1_reg <= {scan_at_max, scan_at_min};
			scan_s2_reg <= scan_s1_reg;
		end
	end

	// History bits: cleared at gating start, set only while gating
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unav_reg  <= 1'b0;
			power_reg <= 1'b0;
		end else if (gating_start) begin
			unav_reg  <= 1'b0; // R8
			power_reg <= 1'b0; // R15
		end else if (gating_active) begin
			// Set-only during gating; value stays as history afterwards
			if (sync2_reg[assl_pkg::ALM_UNAV_BIT]) begin
				unav_reg <= 1'b1; // R8
			end
			if (sync2_reg[assl_pkg::ALM_POWER_BIT]) begin
				power_reg <= 1'b1; // R15
			end
		end
	end

	// Scan limit: set at maximum, cleared at minimum, max wins on a tie
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			limit_reg <= 1'b0;
		end else if (scan_s2_reg[1]) begin
			limit_reg <= 1'b1; // R19
		end else if (scan_s2_reg[0]) begin
			limit_reg <= 1'b0; // R19
		end
	end

	// Live bits pass straight through; unused bits forced to zero
	always_comb begin
		live_next = sync2_reg & assl_pkg::ALARM_USED; // R6 R7 R9 R10 R11 R12 R13 R14 R16 R17 R18
		live_next[assl_pkg::ALM_UNAV_BIT]  = unav_reg;
		live_next[assl_pkg::ALM_POWER_BIT] = power_reg;
		live_next[assl_pkg::ALM_LIMIT_BIT] = limit_reg;
		live_next[15:13] = 3'h0; // R20
	end

	// Registered output image
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			live_alarm_flags <= assl_pkg::ALARM_RST;
		end else begin
			live_alarm_flags <= live_next;
		end
	end

	a_unused_zero: assert property (@(posedge clk) disable iff (!resetn)
		live_alarm_flags[15:13] == 3'h0) // R20
		else $error("unused alarm bits not zero");
	a_live_follow: assert property (@(posedge clk) disable iff (!resetn)
		$rose(sync2_reg[assl_pkg::ALM_BITERR_BIT])
		|=> live_alarm_flags[assl_pkg::ALM_BITERR_BIT]) // R11
		else $error("bit error alarm did not follow");
	a_power_hist_clear: assert property (@(posedge clk) disable iff (!resetn)
		gating_start |=> ##1 !live_alarm_flags[assl_pkg::ALM_POWER_BIT]) // R15
		else $error("power loss history not cleared");
	a_scan_limit_hold: assert property (@(posedge clk) disable iff (!resetn)
		(limit_reg && !scan_s2_reg[0]) |=> limit_reg) // R19
		else $error("scan limit flag dropped early");
endmodule : assl_alarm_reg

// File: design/assl_status_srq.sv
// Primary status, service request mask and alarm change logic
`timescale 1ns/1ns
// What this block does
// R1: Status query returns whole status register
// R2: Masked status bit rising raises request
// R3: Sixteen mask bits gate sixteen status bits; here status bit 6 never requests, so only fifteen are gated
// R4: Mask command takes value or bit name
// R5: ON sets all mask bits, OFF clears
// R6: Alarm register shows live indicator state
// R7: Bit 0 while jitter sync lost
// R8: Bit 1 unavailability, history after gating
// R9: Bit 2 while synthesizer unlocked
// R10: Bit 3 while alarm indication detected
// R11: Bit 4 while bit errors present
// R12: Bit 5 while code errors present
// R13: Bit 6 pattern sync loss
// R14: Bit 7 on any jitter hit
// R15: Bit 8 power loss history per gating
// R16: Bit 9 while transmit clock missing
// R17: Bit 10 while receive clock idle
// R18: Bit 11 while receive data idle
// R19: Bit 12 set at scan max, cleared min
// R20: Alarm bits 13 to 15 read zero
// R21: Status bit 9 on masked alarm change
// R22: Status bit 6 set on each request
// R23: Request mask resets to all zeros
module assl_status_srq (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic [15:0]            alarm_raw,
	input  wire logic                   gating_start,
	input  wire logic                   gating_active,
	input  wire logic                   scan_at_max,
	input  wire logic                   scan_at_min,
	input  wire logic [15:0]            other_status,
	input  wire logic                   request_mask_command,
	input  wire assl_pkg::assl_mask_op_t mask_op,
	input  wire logic [15:0]            mask_value,
	input  wire logic [3:0]             mask_bit_name,
	input  wire logic                   alarm_mask_write,
	input  wire logic [15:0]            alarm_mask_value,
	input  wire logic                   primary_status_query,
	input  wire logic                   alarm_query,
	input  wire logic                   serial_poll,
	input  wire logic                   status_byte_query,
	input  wire logic                   clear_cmd,
	output logic      [15:0]            status_reply,
	output logic                        status_reply_valid,
	output logic      [15:0]            live_alarm_flags,
	output logic      [15:0]            alarm_reply,
	output logic                        alarm_reply_valid,
	output logic      [15:0]            request_mask_reg,
	output logic                        srq_n
);
	logic [15:0] alarm_mask_reg;     // Alarm mask steering alarm change
	logic [15:0] alarm_prev_reg;     // Last alarm image for change detect
	logic        alarm_change_flag;  // Sticky status bit 9
	logic        srq_flag_reg;       // Sticky status bit 6
	logic [15:0] status_now;         // Assembled primary status
	logic [15:0] status_prev_reg;    // Previous status for rise detect
	logic [15:0] rise_masked;        // Masked newly-set status bits
	logic        srq_event;          // A request is generated this cycle
	logic        alarm_change_evt;   // Masked alarm bit changed
	logic        srq_clear;          // Any clear of the request bit
	logic        chg_clear;          // Any clear of the alarm change bit
	logic [15:0] mask_next;          // Next request mask value

	// Bit-name decode to one-hot; shared by the mask command path
	function automatic logic [15:0] name_to_mask(input logic [3:0] idx);
		name_to_mask = 16'h0001 << idx;
	endfunction : name_to_mask

	// Live alarm register
	assl_alarm_reg u_alarm (
		.clk              (clk),
		.resetn           (resetn),
		.alarm_raw        (alarm_raw),
		.gating_start     (gating_start),
		.gating_active    (gating_active),
		.scan_at_max      (scan_at_max),
		.scan_at_min      (scan_at_min),
		.live_alarm_flags (live_alarm_flags)
	);

	// Mask command argument decode
	always_comb begin
		case (mask_op)
			assl_pkg::ASSL_MASK_VALUE: begin
				mask_next = mask_value; // R4
			end
			assl_pkg::ASSL_MASK_NAME: begin
				// A name selects its bit alone, like the matching weight
				mask_next = name_to_mask(mask_bit_name); // R4
			end
			assl_pkg::ASSL_MASK_ON: begin
				mask_next = assl_pkg::ALL_ONES; // R5
			end
			assl_pkg::ASSL_MASK_OFF: begin
				mask_next = assl_pkg::MASK_RST; // R5
			end
			default: begin
				mask_next = request_mask_reg;
			end
		endcase
	end

	// Service request mask; zero after reset so nothing fires early
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			request_mask_reg <= assl_pkg::MASK_RST; // R23
		end else if (request_mask_command) begin
			request_mask_reg <= mask_next; // R3
		end
	end

	// Alarm mask, written by its own command
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alarm_mask_reg <= assl_pkg::MASK_RST;
		end else if (alarm_mask_write) begin
			alarm_mask_reg <= alarm_mask_value;
		end
	end

	// Alarm change detect against the previous image
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alarm_prev_reg <= assl_pkg::ALARM_RST;
		end else begin
			alarm_prev_reg <= live_alarm_flags;
		end
	end

	assign alarm_change_evt = |((alarm_prev_reg ^ live_alarm_flags) & alarm_mask_reg); // R21
	assign chg_clear        = alarm_query | clear_cmd;
	assign srq_clear        = serial_poll | status_byte_query | clear_cmd;

	// Alarm change flag; a new change wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alarm_change_flag <= 1'b0;
		end else if (alarm_change_evt) begin
			alarm_change_flag <= 1'b1; // R21
		end else if (chg_clear) begin
			alarm_change_flag <= 1'b0; // R21
		end
	end

	// Assemble the primary status from outside bits and local flags
	always_comb begin
		status_now = other_status;
		status_now[assl_pkg::STA_CHG_BIT] = alarm_change_flag;
		status_now[assl_pkg::STA_REQ_BIT] = srq_flag_reg;
	end

	// Previous status image for rising-edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_prev_reg <= 16'h0000;
		end else begin
			status_prev_reg <= status_now;
		end
	end

	// Only bits that newly become set and are enabled may request;
	// the request bit itself is excluded so it cannot retrigger.
	always_comb begin
		rise_masked = status_now & ~status_prev_reg & request_mask_reg; // R2 R3
		rise_masked[assl_pkg::STA_REQ_BIT] = 1'b0;
	end
	assign srq_event = |rise_masked; // R2

	// Request flag; generation wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			srq_flag_reg <= 1'b0;
		end else if (srq_event) begin
			srq_flag_reg <= 1'b1; // R22
		end else if (srq_clear) begin
			srq_flag_reg <= 1'b0; // R22
		end
	end

	// Request line follows the flag, active low toward the bus
	assign srq_n = ~srq_flag_reg; // R2

	// Query replies: whole registers, captured for one cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_reply       <= 16'h0000;
			status_reply_valid <= 1'b0;
			alarm_reply        <= assl_pkg::ALARM_RST;
			alarm_reply_valid  <= 1'b0;
		end else begin
			status_reply_valid <= primary_status_query;
			alarm_reply_valid  <= alarm_query;
			if (primary_status_query) begin
				status_reply <= status_now; // R1
			end
			if (alarm_query) begin
				alarm_reply <= live_alarm_flags;
			end
		end
	end

	a_query_whole: assert property (@(posedge clk) disable iff (!resetn)
		primary_status_query |=> (status_reply_valid && status_reply == $past(status_now))) // R1
		else $error("status reply not the whole register");
	a_srq_raise: assert property (@(posedge clk) disable iff (!resetn)
		srq_event |=> (srq_flag_reg && !srq_n)) // R2
		else $error("request not raised");
	a_mask_block: assert property (@(posedge clk) disable iff (!resetn)
		(request_mask_reg == 16'h0000) |-> !srq_event) // R3
		else $error("request with empty mask");
	a_mask_on: assert property (@(posedge clk) disable iff (!resetn)
		(request_mask_command && mask_op == assl_pkg::ASSL_MASK_ON)
		|=> request_mask_reg == 16'hFFFF) // R5
		else $error("mask ON failed");
	a_mask_name: assert property (@(posedge clk) disable iff (!resetn)
		(request_mask_command && mask_op == assl_pkg::ASSL_MASK_NAME)
		|=> $onehot(request_mask_reg)) // R4
		else $error("named mask not one bit");
	a_change_set: assert property (@(posedge clk) disable iff (!resetn)
		alarm_change_evt |=> alarm_change_flag) // R21
		else $error("alarm change not flagged");
	a_request_clear: assert property (@(posedge clk) disable iff (!resetn)
		(serial_poll && !srq_event) |=> !srq_flag_reg ##0 srq_n) // R22
		else $error("serial poll did not clear request");

	c_srq_seen: cover property (@(posedge clk) disable iff (!resetn) srq_event);
	c_alarm_srq: cover property (@(posedge clk) disable iff (!resetn)
		alarm_change_evt ##[1:3] srq_event);
	c_poll_clear: cover property (@(posedge clk) disable iff (!resetn)
		srq_flag_reg ##1 serial_poll ##1 srq_n);
endmodule : assl_status_srq

// File: bench/assl_ctl_model.sv
// Controller model: answers a service request with a serial poll
`timescale 1ns/1ns
module assl_ctl_model (
	input  wire logic clk,
	input  wire logic srq_n,
	input  wire logic poll_en,
	output logic      serial_poll,
	output int        polls
);
	// Poll off the falling edge, one cycle wide, then back off.
	// The back-off lets the request line drop before looking again.
	initial begin
		serial_poll = 1'b0;
		polls = 0;
		forever begin
			@(negedge clk);
			// Only poll when the bench allows it and a request stands
			if (poll_en && srq_n === 1'b0) begin
				serial_poll = 1'b1;
				polls = polls + 1;
				@(negedge clk);
				serial_poll = 1'b0;
				repeat (3) @(negedge clk);
			end
		end
	end
endmodule : assl_ctl_model

// File: bench/tb.sv
// Self-checking bench for the alarm, status and request block
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0;                      // System clock
	logic        resetn = 1'b0;                   // Reset, active low
	logic [15:0] alarm_raw = 16'h0000;            // Alarm pins
	logic        gating_start = 1'b0;             // Gating start pulse
	logic        gating_active = 1'b0;            // Gating level
	logic        scan_at_max = 1'b0;              // Scan limits
	logic        scan_at_min = 1'b0;
	logic [15:0] other_status = 16'h0000;         // Rest of status
	logic        request_mask_command = 1'b0;
	assl_pkg::assl_mask_op_t mask_op = assl_pkg::ASSL_MASK_VALUE;
	logic [15:0] mask_value = 16'h0000;
	logic [3:0]  mask_bit_name = 4'h0;
	logic        alarm_mask_write = 1'b0;
	logic [15:0] alarm_mask_value = 16'h0000;
	logic        primary_status_query = 1'b0;
	logic        alarm_query = 1'b0;
	logic        status_byte_query = 1'b0;
	logic        clear_cmd = 1'b0;
	logic        poll_en = 1'b0;                  // Lets the model poll
	logic        serial_poll;
	logic [15:0] status_reply, alarm_reply, live_alarm_flags, request_mask_reg;
	logic        status_reply_valid, alarm_reply_valid, srq_n;
	int          polls;
	int          num_errors = 0;
	int          n_compared = 0;
	logic [15:0] r;                               // Last reply
	// Rows: pin pattern in the upper half, expected flags in the lower
	logic [31:0] rows [13] = '{32'h0001_0001, 32'h0004_0004, 32'h0008_0008,
		32'h0010_0010, 32'h0020_0020, 32'h0040_0040, 32'h0080_0080, 32'h0200_0200,
		32'h0400_0400, 32'h0800_0800, 32'hE000_0000, 32'h0102_0000, 32'h0000_0000};

	assl_status_srq assl_status_srq_inst (
		.clk, .resetn, .alarm_raw, .gating_start, .gating_active, .scan_at_max,
		.scan_at_min, .other_status, .request_mask_command, .mask_op, .mask_value,
		.mask_bit_name, .alarm_mask_write, .alarm_mask_value, .primary_status_query,
		.alarm_query, .serial_poll, .status_byte_query, .clear_cmd, .status_reply,
		.status_reply_valid, .live_alarm_flags, .alarm_reply, .alarm_reply_valid,
		.request_mask_reg, .srq_n
	);

	assl_ctl_model assl_ctl_model_inst (.clk, .srq_n, .poll_en, .serial_poll, .polls);

	// Free-running clock
	always #5 clk = ~clk;

	// Case equality so an unknown never counts as a match
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Single place where the run ends
	task automatic wrap_up;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Bounded wait for the request line; a timeout ends the run
	task automatic wait_srq(input logic lvl);
		int i;
		for (i = 0; i < 12 && srq_n !== lvl; i++)
			@(negedge clk);
		check({15'h0000, srq_n}, {15'h0000, lvl});
		if (srq_n !== lvl)
			wrap_up;
	endtask : wait_srq

	// One-cycle query pulse, reply caught within a bounded wait
	task automatic query(input bit alm, output logic [15:0] q);
		int i;
		// Idle edge first, so back-to-back queries never re-drive a strobe in one step
		@(negedge clk);
		alarm_query = alm;
		primary_status_query = !alm;
		@(negedge clk);
		alarm_query = 1'b0;
		primary_status_query = 1'b0;
		for (i = 0; i < 4 && (alm ? alarm_reply_valid : status_reply_valid) !== 1'b1; i++)
			@(negedge clk);
		q = alm ? alarm_reply : status_reply;
		if (i == 4) begin
			num_errors++;
			wrap_up;
		end
	endtask : query

	// Mask command pulse, then one cycle for the mask to land
	task automatic mask_cmd(input assl_pkg::assl_mask_op_t op, input logic [15:0] v,
		input logic [3:0] nm);
		mask_op = op;
		mask_value = v;
		mask_bit_name = nm;
		request_mask_command = 1'b1;
		@(negedge clk);
		request_mask_command = 1'b0;
		@(negedge clk);
	endtask : mask_cmd

	// Main sequence; inputs change on falling edges only
	initial begin
		cyc(12);
		resetn = 1'b1;
		@(negedge clk);
		check(request_mask_reg, 16'h0000);
		check({15'h0000, srq_n}, 16'h0001);
		// Alarm table: three edges of sync and output register
		foreach (rows[k]) begin
			alarm_raw = rows[k][31:16];
			cyc(3);
			check(live_alarm_flags, rows[k][15:0]);
		end
		// Each load starts from a different mask so an ignored command shows
		mask_cmd(assl_pkg::ASSL_MASK_ON, 16'h0000, 4'h0);
		check(request_mask_reg, 16'hFFFF);
		mask_cmd(assl_pkg::ASSL_MASK_VALUE, 16'h0020, 4'h0);
		check(request_mask_reg, 16'h0020);
		mask_cmd(assl_pkg::ASSL_MASK_OFF, 16'hFFFF, 4'hF);
		check(request_mask_reg, 16'h0000);
		mask_cmd(assl_pkg::ASSL_MASK_NAME, 16'h0000, 4'h5);
		check(request_mask_reg, 16'h0020);
		// Unmasked bits rise: no request
		other_status = 16'h8008;
		cyc(4);
		check({15'h0000, srq_n}, 16'h0001);
		query(1'b0, r);
		check(r, 16'h8008);
		// Masked error bit rises
		other_status = 16'h8028;
		wait_srq(1'b0);
		query(1'b0, r);
		check(r, 16'h8068);
		poll_en = 1'b1;
		wait_srq(1'b1);
		check(16'(polls), 16'h0001);
		poll_en = 1'b0;
		query(1'b0, r);
		check(r, 16'h8028);
		// All bits enabled, cleared by the status byte query
		other_status = 16'h0000;
		mask_cmd(assl_pkg::ASSL_MASK_ON, 16'h0000, 4'h0);
		other_status = 16'h0001;
		wait_srq(1'b0);
		status_byte_query = 1'b1;
		cyc(1);
		status_byte_query = 1'b0;
		wait_srq(1'b1);
		// All bits disabled: a rise raises nothing
		mask_cmd(assl_pkg::ASSL_MASK_OFF, 16'h0000, 4'h0);
		other_status = 16'h0005;
		cyc(4);
		check({15'h0000, srq_n}, 16'h0001);
		// Masked alarm change reaches the request through status bit 9
		alarm_mask_value = 16'h0040;
		alarm_mask_write = 1'b1;
		cyc(1);
		alarm_mask_write = 1'b0;
		mask_cmd(assl_pkg::ASSL_MASK_VALUE, 16'h0200, 4'h0);
		alarm_raw = 16'h0040;
		wait_srq(1'b0);
		query(1'b0, r);
		check(r & 16'h0240, 16'h0240);
		query(1'b1, r);
		check(r, 16'h0040);
		query(1'b0, r);
		check(r & 16'h0200, 16'h0000);
		clear_cmd = 1'b1;
		cyc(1);
		clear_cmd = 1'b0;
		wait_srq(1'b1);
		// History bits survive the end of gating, cleared at next start
		alarm_raw = 16'h0000;
		gating_start = 1'b1;
		gating_active = 1'b1;
		cyc(1);
		gating_start = 1'b0;
		alarm_raw = 16'h0102;
		cyc(4);
		alarm_raw = 16'h0000;
		gating_active = 1'b0;
		cyc(4);
		check(live_alarm_flags, 16'h0102);
		gating_start = 1'b1;
		cyc(1);
		gating_start = 1'b0;
		cyc(4);
		check(live_alarm_flags, 16'h0000);
		// Scan extremity: set at maximum, held, cleared at minimum
		scan_at_max = 1'b1;
		cyc(4);
		scan_at_max = 1'b0;
		cyc(4);
		check(live_alarm_flags, 16'h1000);
		scan_at_min = 1'b1;
		cyc(4);
		scan_at_min = 1'b0;
		check(live_alarm_flags, 16'h0000);
		// Mid-run reset with a full mask and a request standing from the alarm change
		mask_cmd(assl_pkg::ASSL_MASK_ON, 16'h0000, 4'h0);
		resetn = 1'b0;
		cyc(1);
		check(request_mask_reg, 16'h0000);
		check({15'h0000, srq_n}, 16'h0001);
		resetn = 1'b1;
		cyc(2);
		check(request_mask_reg, 16'h0000);
		check(live_alarm_flags, 16'h0000);
		wrap_up;
	end
endmodule : tb
